// [hdl/cssu_core.sv]
/*
 * Compare and string search unit: decodes instruction words, reads operands, updates flags, pointer, counter.
 * Assumes two combinational register file read ports, one write port and a memory port acked by mem_ack_in.
 */
`timescale 1ns/100ps
`include "cssu_cfg.svh"

module cssu_core
	import cssu_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        core_clk_in,
	input  wire logic        rstn_in,
	input  wire logic        ce_in,
	// Instruction words
	input  wire logic        iw_valid_in,
	input  wire logic [15:0] iw_data_in,
	output logic             iw_ready_out,
	// Register file
	output logic [3:0]       rf_a_idx_out,
	input  wire logic [31:0] rf_a_data_in,
	output logic [3:0]       rf_b_idx_out,
	input  wire logic [31:0] rf_b_data_in,
	output logic             rf_we_out,
	output logic [3:0]       rf_waddr_out,
	output logic [31:0]      rf_wdata_out,
	// Memory operand
	output logic             mem_req_out,
	output logic [31:0]      mem_addr_out,
	output cssu_size_e       mem_size_out,
	input  wire logic        mem_ack_in,
	input  wire logic [31:0] mem_rdata_in,
	// Control and status
	input  wire logic [1:0]  addr_mode_in,
	input  wire logic        irq_in,
	output cssu_flags_s      flags_out,
	output logic             flags_we_out,
	output logic             busy_out,
	output logic             done_out,
	output logic             illegal_out,
	output logic             yield_out
);

	// -------------------------------------------------------------------------
	// Functions
	// -------------------------------------------------------------------------
	function automatic cssu_dec_s decode(input logic [15:0] w);
		cssu_dec_s r;
		logic      is_long;
		r       = '0;
		is_long = (w[15:8] == `CSSU_OP_RR_L) || (w[15:8] == `CSSU_OP_RI_L) ||
		          (w[15:8] == `CSSU_OP_RE_L) || (w[15:8] == `CSSU_OP_SRCH_L);
		if (w[15:9] == `CSSU_OP_RR_BW || w[15:8] == `CSSU_OP_RR_L) begin
			r.ok   = 1'b1;
			r.kind = K_RR;
		end else if (w[15:9] == `CSSU_OP_RI_BW || w[15:8] == `CSSU_OP_RI_L) begin
			r.ok   = 1'b1;
			r.kind = (w[7:4] == 4'h0) ? K_RIMM : K_RIR;
		end else if (w[15:9] == `CSSU_OP_RE_BW || w[15:8] == `CSSU_OP_RE_L) begin
			r.ok   = 1'b1;
			r.kind = K_REAM;
		end else if (w[7:4] != 4'h0 && ((w[15:9] == `CSSU_OP_MI_BW && w[3:0] == `CSSU_NIB_IMM_BW) ||
		             (w[15:8] == `CSSU_OP_MI_L && w[3:0] == `CSSU_NIB_IMM_L))) begin
			r.ok    = 1'b1;
			r.kind  = K_MIR;
			is_long = (w[3:0] == `CSSU_NIB_IMM_L);
		end else if ((w[15:9] == `CSSU_OP_ME_BW && w[3:0] == `CSSU_NIB_IMM_BW) ||
		             (w[15:8] == `CSSU_OP_ME_L && w[3:0] == `CSSU_NIB_IMM_L)) begin
			r.ok    = 1'b1;
			r.kind  = K_MEAM;
			is_long = (w[3:0] == `CSSU_NIB_IMM_L);
		end else if ((w[15:9] == `CSSU_OP_SRCH_BW || w[15:8] == `CSSU_OP_SRCH_L) && w[7:4] != 4'h0 &&
		             (w[3:0] == `CSSU_NIB_STEP_UP || w[3:0] == `CSSU_NIB_RPT_UP ||
		              w[3:0] == `CSSU_NIB_STEP_DN || w[3:0] == `CSSU_NIB_RPT_DN)) begin
			r.ok   = 1'b1;
			r.kind = K_SRCH;
			r.up   = (w[3:0] == `CSSU_NIB_STEP_UP) || (w[3:0] == `CSSU_NIB_RPT_UP);
			r.rpt  = (w[3:0] == `CSSU_NIB_RPT_UP) || (w[3:0] == `CSSU_NIB_RPT_DN);
		end
		r.size = is_long ? SZ_L : (w[8] ? SZ_W : SZ_B);
		return r;
	endfunction : decode

	// Byte registers 0-7 are high bytes, 8-15 low bytes of word registers 0-7
	function automatic logic [3:0] reg_idx(input cssu_size_e sz, input logic [3:0] n);
		return (sz == SZ_B) ? {1'b0, n[2:0]} : n;
	endfunction : reg_idx

	function automatic logic [31:0] reg_val(input cssu_size_e sz, input logic [3:0] n, input logic [31:0] v);
		return (sz == SZ_B) ? {24'h000000, n[3] ? v[7:0] : v[15:8]} : (sz == SZ_W) ? {16'h0000, v[15:0]} : v;
	endfunction : reg_val

	// Moves the operand to the top so one 32-bit adder serves all sizes
	function automatic logic [31:0] align(input cssu_size_e sz, input logic [31:0] v);
		return (sz == SZ_B) ? {v[7:0], 24'h000000} : (sz == SZ_W) ? {v[15:0], 16'h0000} : v;
	endfunction : align

	// Codes 8-F test the inverse of codes 0-7
	function automatic logic cc_eval(input logic [3:0] cc, input cssu_flags_s f);
		logic r;
		case (cc[2:0])
			3'h0: r = 1'b0;
			3'h1: r = f.s ^ f.v;
			3'h2: r = (f.s ^ f.v) | f.z;
			3'h3: r = f.c | f.z;
			3'h4: r = f.v;
			3'h5: r = f.s;
			3'h6: r = f.z;
			default: r = f.c;
		endcase
		return cc[3] ? ~r : r;
	endfunction : cc_eval

	// -------------------------------------------------------------------------
	// Datapath
	// -------------------------------------------------------------------------
	cssu_state_s q;
	cssu_state_s d;
	cssu_dec_s   dec;
	logic [3:0]  dst_reg;
	logic [31:0] src_val;
	logic [31:0] dst_val;
	logic [31:0] d_al;
	logic [31:0] s_al;
	logic [31:0] res;
	logic        carry;
	cssu_flags_s cmp_f;
	logic [31:0] step;
	logic [31:0] ptr_full;
	logic [15:0] cnt_new;
	logic        compact;

	assign dec     = decode(iw_data_in);
	assign compact = (addr_mode_in == `CSSU_MODE_COMPACT);
	assign dst_reg = (q.kind == K_SRCH) ? q.w2[7:4] : q.op[3:0];
	assign src_val = (q.kind == K_RR) ? reg_val(q.size, q.op[7:4], rf_a_data_in) :
	                 (q.kind == K_RIMM || q.kind == K_MIR || q.kind == K_MEAM) ? q.imm : q.opnd;
	assign dst_val = (q.kind == K_MIR || q.kind == K_MEAM) ? q.opnd : reg_val(q.size, dst_reg, rf_b_data_in);
	assign d_al    = align(q.size, dst_val);
	assign s_al    = align(q.size, src_val);
	assign {carry, res} = {1'b0, d_al} + {1'b0, ~s_al} + 33'h000000001;
	assign cmp_f.c = ~carry;
	assign cmp_f.z = (res == 32'h00000000);
	assign cmp_f.s = res[31];
	assign cmp_f.v = (d_al[31] != s_al[31]) && (res[31] != d_al[31]);

	assign step     = (q.size == SZ_B) ? `CSSU_STEP_BYTE : (q.size == SZ_W) ? `CSSU_STEP_WORD : `CSSU_STEP_LONG;
	assign ptr_full = q.up ? rf_a_data_in + step : rf_a_data_in - step;
	assign cnt_new  = rf_b_data_in[15:0] - `CSSU_CNT_ONE;

	// -------------------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------------------
	assign iw_ready_out = (q.st == S_IDLE) || (q.st == S_W2) || (q.st == S_EXT) || (q.st == S_IMM);
	assign rf_a_idx_out = (q.st == S_EXEC) ? reg_idx(q.size, q.op[7:4]) : q.op[7:4];
	assign rf_b_idx_out = (q.st == S_WCNT) ? q.w2[11:8] : reg_idx(q.size, dst_reg);
	// Only pointer and counter are ever written back
	assign rf_we_out    = ce_in && (q.st == S_WPTR || q.st == S_WCNT);
	assign rf_waddr_out = (q.st == S_WPTR) ? q.op[7:4] : q.w2[11:8];
	assign rf_wdata_out = (q.st == S_WCNT) ? {rf_b_data_in[31:16], cnt_new} :
	                      compact ? {rf_a_data_in[31:16], ptr_full[15:0]} : ptr_full;
	assign mem_req_out  = (q.st == S_MEM);
	assign mem_addr_out = q.addr;
	assign mem_size_out = q.size;
	assign flags_out    = q.flags;
	assign flags_we_out = q.flags_we;
	assign busy_out     = (q.st != S_IDLE);
	assign done_out     = q.done;
	assign illegal_out  = q.illegal;
	assign yield_out    = q.yield;

	// -------------------------------------------------------------------------
	// Sequencer
	// -------------------------------------------------------------------------
	always_comb begin
		d = q;
		if (ce_in) begin
			d.flags_we = 1'b0;
			d.done     = 1'b0;
			d.illegal  = 1'b0;
			d.yield    = 1'b0;
			case (q.st)
				S_IDLE: if (iw_valid_in) begin
					d.op       = iw_data_in;
					d.kind     = dec.kind;
					d.size     = dec.size;
					d.up       = dec.up;
					d.rpt      = dec.rpt;
					d.addr     = 32'h00000000;
					d.imm      = 32'h00000000;
					d.ext_left = (iw_data_in[5:4] == 2'h0) ? 2'h1 : iw_data_in[5:4];
					d.imm_left = (dec.size == SZ_L) ? 2'h2 : 2'h1;
					if (!dec.ok)
						d.illegal = 1'b1;
					else if (dec.kind == K_SRCH)
						d.st = S_W2;
					else if (dec.kind == K_RR)
						d.st = S_EXEC;
					else if (dec.kind == K_RIR)
						d.st = S_ADDR;
					else if (dec.kind == K_REAM || dec.kind == K_MEAM)
						d.st = S_EXT;
					else
						d.st = S_IMM;
				end
				S_W2: if (iw_valid_in) begin
					d.w2 = iw_data_in;
					d.st = S_ADDR;
				end
				S_EXT: if (iw_valid_in) begin
					d.addr     = {q.addr[15:0], iw_data_in};
					d.ext_left = q.ext_left - 2'h1;
					if (q.ext_left == 2'h1)
						d.st = (q.kind == K_MEAM) ? S_IMM : S_MEM;
				end
				S_IMM: if (iw_valid_in) begin
					d.imm      = {q.imm[15:0], iw_data_in};
					d.imm_left = q.imm_left - 2'h1;
					if (q.imm_left == 2'h1)
						d.st = (q.kind == K_RIMM) ? S_EXEC : (q.kind == K_MIR) ? S_ADDR : S_MEM;
				end
				S_ADDR: begin
					d.addr = compact ? {16'h0000, rf_a_data_in[15:0]} : rf_a_data_in;
					d.st   = S_MEM;
				end
				S_MEM: if (mem_ack_in) begin
					d.opnd = mem_rdata_in;
					d.st   = S_EXEC;
				end
				S_EXEC: begin
					d.flags.c = cmp_f.c;
					d.flags.s = cmp_f.s;
					if (q.kind == K_SRCH) begin
						d.hit     = cc_eval(q.w2[3:0], cmp_f);
						d.flags.z = cc_eval(q.w2[3:0], cmp_f);
						d.st      = S_WPTR;
					end else begin
						d.flags.z  = cmp_f.z;
						d.flags.v  = cmp_f.v;
						d.flags_we = 1'b1;
						d.done     = 1'b1;
						d.st       = S_IDLE;
					end
				end
				S_WPTR: d.st = S_WCNT;
				S_WCNT: begin
					d.flags.v  = (cnt_new == 16'h0000);
					d.flags_we = 1'b1;
					// Stopping here leaves pointer and counter ready for a restart
					if (q.rpt && !q.hit && cnt_new != 16'h0000) begin
						if (irq_in) begin
							d.yield = 1'b1;
							d.st    = S_IDLE;
						end else begin
							d.st = S_ADDR;
						end
					end else begin
						d.done = 1'b1;
						d.st   = S_IDLE;
					end
				end
				default: d.st = S_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// -------------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);

	a_ptr_up_step: assert property ((q.st == S_WPTR && q.up && !compact) |->
		(rf_wdata_out - rf_a_data_in) == ((q.size == SZ_B) ? 32'h1 : (q.size == SZ_W) ? 32'h2 : 32'h4))
		else $error("pointer did not step up by element size");
	a_ptr_dn_step: assert property ((q.st == S_WPTR && !q.up && !compact) |->
		(rf_a_data_in - rf_wdata_out) == ((q.size == SZ_B) ? 32'h1 : (q.size == SZ_W) ? 32'h2 : 32'h4))
		else $error("pointer did not step down by element size");
	a_ptr_compact: assert property ((q.st == S_WPTR && compact) |->
		rf_wdata_out[31:16] == rf_a_data_in[31:16]) else $error("compact pointer touched upper half");
	a_cnt_order: assert property ((q.st == S_WPTR && ce_in) |=> (q.st == S_WCNT))
		else $error("counter update did not follow pointer update");
	a_cnt_dec: assert property ((q.st == S_WCNT) |->
		rf_waddr_out == q.w2[11:8] && rf_wdata_out[15:0] + 16'h0001 == rf_b_data_in[15:0])
		else $error("counter not decremented by one");
	a_no_dst_write: assert property (rf_we_out |->
		q.kind == K_SRCH && (rf_waddr_out == q.op[7:4] || rf_waddr_out == q.w2[11:8])) else $error("stray register write");
	a_carry_borrow: assert property ((q.st == S_EXEC && ce_in) |=>
		flags_out.c == ($past(d_al) < $past(s_al))) else $error("carry flag does not show borrow");
	a_sign_result: assert property ((q.st == S_EXEC && ce_in) |=>
		flags_out.s == (($past(d_al) - $past(s_al)) >= 32'h80000000)) else $error("sign flag wrong");
	a_v_zero_cnt: assert property ((q.st == S_WCNT && ce_in) |=>
		flags_we_out && flags_out.v == ($past(rf_b_data_in[15:0]) == 16'h0001)) else $error("overflow flag wrong");
	a_repeat_loop: assert property ((q.st == S_WCNT && ce_in && q.rpt && !q.hit && !irq_in &&
		rf_b_data_in[15:0] != 16'h0001) |=> (q.st == S_ADDR) ##1 (q.st == S_MEM || !$past(ce_in)))
		else $error("repeat did not continue");
	a_yield_clean: assert property ((q.st == S_WCNT && ce_in && q.rpt && !q.hit && irq_in &&
		rf_b_data_in[15:0] != 16'h0001) |=> yield_out && !busy_out && !done_out) else $error("yield not clean");

endmodule : cssu_core

// [shared/cssu_cfg.svh]
/*
 * Opcode patterns, sub-opcode nibbles, mode codes and reset values of the
 * compare and string search unit.
 * Assumes it is included by bare name from the unit's design file.
 */
`ifndef CSSU_CFG_SVH
`define CSSU_CFG_SVH

// -----------------------------------------------------------------------------
// First-byte patterns (7-bit forms carry the size bit below them)
// -----------------------------------------------------------------------------
`define CSSU_OP_RR_BW    7'h45
`define CSSU_OP_RR_L     8'h90
`define CSSU_OP_RI_BW    7'h05
`define CSSU_OP_RI_L     8'h10
`define CSSU_OP_RE_BW    7'h25
`define CSSU_OP_RE_L     8'h50
`define CSSU_OP_MI_BW    7'h06
`define CSSU_OP_MI_L     8'h0D
`define CSSU_OP_ME_BW    7'h26
`define CSSU_OP_ME_L     8'h4D
`define CSSU_OP_SRCH_BW  7'h5D
`define CSSU_OP_SRCH_L   8'hB9

// -----------------------------------------------------------------------------
// Low-nibble sub-opcodes
// -----------------------------------------------------------------------------
`define CSSU_NIB_IMM_BW  4'h1
`define CSSU_NIB_IMM_L   4'h3
`define CSSU_NIB_STEP_UP 4'h0
`define CSSU_NIB_RPT_UP  4'h4
`define CSSU_NIB_STEP_DN 4'h8
`define CSSU_NIB_RPT_DN  4'hC

// -----------------------------------------------------------------------------
// Address modes, steps and reset values
// -----------------------------------------------------------------------------
`define CSSU_MODE_COMPACT 2'h0
`define CSSU_STEP_BYTE    32'h00000001
`define CSSU_STEP_WORD    32'h00000002
`define CSSU_STEP_LONG    32'h00000004
`define CSSU_CNT_ONE      16'h0001
`define CSSU_RST_FLAGS    4'h0

`endif

// [shared/cssu_pkg.sv]
/*
 * Types of the compare and string search unit: states, instruction kinds,
 * operand sizes, flag group, decode result and the unit's state record.
 * Assumes nothing of its surroundings.
 */
package cssu_pkg;

	typedef enum logic [3:0] {S_IDLE, S_W2, S_EXT, S_IMM, S_ADDR, S_MEM, S_EXEC, S_WPTR, S_WCNT} cssu_state_e;
	typedef enum logic [2:0] {K_RR, K_RIMM, K_RIR, K_REAM, K_MIR, K_MEAM, K_SRCH} cssu_kind_e;
	typedef enum logic [1:0] {SZ_B, SZ_W, SZ_L} cssu_size_e;

	typedef struct packed {
		logic c;
		logic z;
		logic s;
		logic v;
	} cssu_flags_s;

	typedef struct packed {
		logic       ok;
		cssu_kind_e kind;
		cssu_size_e size;
		logic       up;
		logic       rpt;
	} cssu_dec_s;

	typedef struct packed {
		cssu_state_e st;
		cssu_kind_e  kind;
		cssu_size_e  size;
		logic        up;
		logic        rpt;
		logic [15:0] op;
		logic [15:0] w2;
		logic [1:0]  ext_left;
		logic [1:0]  imm_left;
		logic [31:0] addr;
		logic [31:0] imm;
		logic [31:0] opnd;
		logic        hit;
		cssu_flags_s flags;
		logic        flags_we;
		logic        done;
		logic        illegal;
		logic        yield;
	} cssu_state_s;

endpackage : cssu_pkg

// [verification/cssu_core_bench.sv]
/*
 * Self-checking bench of the compare and string search unit: register file
 * model, memory responder, reference flag and pointer model, random stimulus.
 * Assumes cssu_pkg and cssu_core are compiled before it.
 */
`timescale 1ns/100ps
module cssu_core_bench import cssu_pkg::*; ;
	logic        core_clk_in, rstn_in, ce_in, iw_valid_in, mem_ack_in, irq_in;
	logic [15:0] iw_data_in;
	logic [31:0] rf_a_data_in, rf_b_data_in, mem_rdata_in, rf_wdata_out, mem_addr_out;
	logic [1:0]  addr_mode_in;
	logic        iw_ready_out, rf_we_out, mem_req_out, flags_we_out, busy_out, done_out, illegal_out, yield_out;
	logic [3:0]  rf_a_idx_out, rf_b_idx_out, rf_waddr_out;
	cssu_size_e  mem_size_out;
	cssu_flags_s flags_out;
	logic [31:0] regs [16];
	int          error_cnt, check_count, wr_cnt;
	integer      seed, mseed;

	cssu_core cssu_core_inst (.core_clk_in, .rstn_in, .ce_in, .iw_valid_in, .iw_data_in, .iw_ready_out,
		.rf_a_idx_out, .rf_a_data_in, .rf_b_idx_out, .rf_b_data_in, .rf_we_out, .rf_waddr_out,
		.rf_wdata_out, .mem_req_out, .mem_addr_out, .mem_size_out, .mem_ack_in, .mem_rdata_in,
		.addr_mode_in, .irq_in, .flags_out, .flags_we_out, .busy_out, .done_out, .illegal_out, .yield_out);

	// -------------------------------------------------------------------------
	// Surroundings: clock, register file, memory
	// -------------------------------------------------------------------------
	initial begin
		core_clk_in = 1'b0;
		forever #2 core_clk_in = ~core_clk_in;
	end

	assign rf_a_data_in = regs[rf_a_idx_out];
	assign rf_b_data_in = regs[rf_b_idx_out];

	always @(posedge core_clk_in) begin
		if (rf_we_out === 1'b1) begin
			regs[rf_waddr_out] <= rf_wdata_out;
			wr_cnt <= wr_cnt + 1;
		end
	end

	// Random latency; data inverted while no request is raised so stale values never match
	always @(negedge core_clk_in) begin
		mem_ack_in   <= mem_req_out & (($random(mseed) & 3) != 0);
		mem_rdata_in <= mval(mem_addr_out, int'(mem_size_out)) ^ (mem_req_out ? 32'h0 : 32'hFFFFFFFF);
	end

	// -------------------------------------------------------------------------
	// Reference functions
	// -------------------------------------------------------------------------
	function automatic logic [31:0] msk(input int sz);
		return (sz == 0) ? 32'hFF : (sz == 1) ? 32'hFFFF : 32'hFFFFFFFF;
	endfunction : msk

	function automatic logic [31:0] mval(input logic [31:0] a, input int sz);
		return ((a * 32'h9E3779B1) ^ 32'h5A5A1234) & msk(sz);
	endfunction : mval

	// Byte fields 0-7 name the high byte, 8-15 the low byte of register n-8
	function automatic logic [31:0] rdv(input logic [3:0] i, input int sz);
		if (sz == 0)
			return (i < 8) ? 32'(regs[i][15:8]) : 32'(regs[i - 8][7:0]);
		return (sz == 1) ? 32'(regs[i][15:0]) : regs[i];
	endfunction : rdv

	function automatic cssu_flags_s cmp(input logic [31:0] d, input logic [31:0] s, input int sz);
		cssu_flags_s f;
		logic [31:0] r;
		int          b;
		b   = (sz == 0) ? 7 : (sz == 1) ? 15 : 31;
		r   = (d - s) & msk(sz);
		f.c = (s & msk(sz)) > (d & msk(sz));
		f.z = (r == 32'h0);
		f.s = r[b];
		f.v = (d[b] != s[b]) && (r[b] != d[b]);
		return f;
	endfunction : cmp

	function automatic logic cc_ok(input logic [3:0] cc, input cssu_flags_s f);
		logic        lt;
		logic [15:0] t;
		lt = f.s ^ f.v;
		t  = {!f.c, !f.z, !f.s, !f.v, !(f.c | f.z), !(f.z | lt), !lt, 1'b1,
		      f.c, f.z, f.s, f.v, f.c | f.z, f.z | lt, lt, 1'b0};
		return t[cc];
	endfunction : cc_ok

	// -------------------------------------------------------------------------
	// Checking and driving
	// -------------------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic tally_and_finish;
		if (error_cnt == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish

	// Entered at a falling edge; the word is taken at the next rising edge with ready
	task automatic send(input logic [15:0] w);
		int n;
		n           = 0;
		iw_valid_in = 1'b1;
		iw_data_in  = w;
		while (iw_ready_out !== 1'b1 && n < 50) begin
			@(negedge core_clk_in);
			n++;
		end
		if (n >= 50) begin
			error_cnt++;
			tally_and_finish();
		end
		@(negedge core_clk_in);
	endtask : send

	task automatic finish_op;
		int n;
		iw_valid_in = 1'b0;
		// Enable drops now and then; the unit must hold all its state meanwhile
		for (n = 0; n < 4000; n++) begin
			@(negedge core_clk_in);
			if (done_out === 1'b1 || yield_out === 1'b1)
				break;
			ce_in = (($random(seed) & 7) != 0);
		end
		ce_in = 1'b1;
		if (n == 4000) begin
			error_cnt++;
			tally_and_finish();
		end
		chk("flags strobe", 32'(flags_we_out), 32'h1);
	endtask : finish_op

	// Plain compares: 0 register, 1 indirect source, 2 immediate to memory, 3 immediate,
	// 4 and 5 like 1 and 2 but addressed by extension words
	task automatic plain(input int kind, input int sz);
		logic [3:0]  rs, rd, eam;
		logic [31:0] d, s, a, imm, ea;
		int          n;
		rs           = 4'h1 + 4'(($random(seed) & 32'h7FFFFFFF) % 15);
		rd           = 4'($random(seed));
		eam          = 4'($random(seed));
		imm          = $random(seed);
		ea           = $random(seed);
		n            = (eam[1:0] == 2'h0) ? 1 : int'(eam[1:0]);
		addr_mode_in = 2'($random(seed));
		a            = (kind >= 4) ? ((n == 1) ? {16'h0, ea[15:0]} : ea) :
		               (addr_mode_in == 2'h0) ? {16'h0, regs[rs][15:0]} : regs[rs];
		s            = (kind == 0) ? rdv(rs, sz) : (kind == 1 || kind == 4) ? mval(a, sz) : imm & msk(sz);
		d            = (kind == 2 || kind == 5) ? mval(a, sz) : rdv(rd, sz);
		wr_cnt       = 0;
		if (kind == 0)
			send(sz == 2 ? {8'h90, rs, rd} : {7'h45, sz[0], rs, rd});
		else if (kind == 1)
			send(sz == 2 ? {8'h10, rs, rd} : {7'h05, sz[0], rs, rd});
		else if (kind == 2)
			send(sz == 2 ? {8'h0D, rs, 4'h3} : {7'h06, sz[0], rs, 4'h1});
		else if (kind == 3)
			send(sz == 2 ? {8'h10, 4'h0, rd} : {7'h05, sz[0], 4'h0, rd});
		else if (kind == 4)
			send(sz == 2 ? {8'h50, eam, rd} : {7'h25, sz[0], eam, rd});
		else
			send(sz == 2 ? {8'h4D, eam, 4'h3} : {7'h26, sz[0], eam, 4'h1});
		// The last two extension words form the address, high word first
		if (kind >= 4) begin
			if (n == 3)
				send(16'($random(seed)));
			if (n >= 2)
				send(ea[31:16]);
			send(ea[15:0]);
		end
		if (kind == 2 || kind == 3 || kind == 5) begin
			if (sz == 2)
				send(imm[31:16]);
			send(sz == 0 ? {imm[7:0], imm[7:0]} : imm[15:0]);
		end
		finish_op();
		chk("plain flags", 32'(flags_out), 32'(cmp(d, s, sz)));
		chk("plain writes", wr_cnt, 0);
	endtask : plain

	task automatic srch(input int sz, input logic up, input logic rpt, input logic irq,
	                    input logic [15:0] cnt0, input logic [3:0] cc, input int k);
		logic [3:0]  rs, r, rg, rd;
		logic [31:0] p, a, d, dreg, step;
		logic [15:0] c;
		logic        hit, yld, md;
		cssu_flags_s f;
		// Source, counter and destination kept apart
		rs           = 4'h1 + 4'($random(seed) & 1);
		r            = 4'h4 + 4'($random(seed) & 1);
		rg           = 4'h6 + 4'($random(seed) & 1);
		rd           = (sz == 0) ? rg + 4'h8 : rg;
		step         = 32'h1 << sz;
		addr_mode_in = 2'($random(seed));
		md           = (addr_mode_in != 2'h0);
		regs[r][15:0] = cnt0;
		p            = regs[rs] + (up ? step * k : -step * k);
		a            = md ? p : {16'h0, p[15:0]};
		if (sz == 0)
			regs[rg][7:0] = mval(a, 0);
		else if (sz == 1)
			regs[rg][15:0] = mval(a, 1);
		else
			regs[rg] = mval(a, 2);
		d      = rdv(rd, sz);
		dreg   = regs[rg];
		p      = regs[rs];
		c      = cnt0;
		irq_in = irq;
		send(sz == 2 ? {8'hB9, rs, !up, rpt, 2'b00} : {7'h5D, sz[0], rs, !up, rpt, 2'b00});
		send({4'h0, r, rd, cc});
		finish_op();
		irq_in = 1'b0;
		do begin
			a   = md ? p : {16'h0, p[15:0]};
			f   = cmp(d, mval(a, sz), sz);
			hit = cc_ok(cc, f);
			p   = md ? p + (up ? step : -step) : {p[31:16], p[15:0] + (up ? step[15:0] : -step[15:0])};
			c   = c - 16'h1;
			f.z = hit;
			f.v = (c == 16'h0);
		end while (rpt && !hit && c != 16'h0 && !irq);
		yld = rpt && irq && !hit && c != 16'h0;
		chk("yield", 32'(yield_out), 32'(yld));
		chk("pointer", regs[rs], p);
		chk("counter", 32'(regs[r][15:0]), 32'(c));
		chk("dest reg", regs[rg], dreg);
		if (!yld)
			chk("search flags", 32'(flags_out), 32'(f));
	endtask : srch

	// -------------------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------------------
	initial begin
		seed         = 32'h16d88eaf;
		mseed        = 32'h16d88eaf;
		rstn_in      = 1'b0;
		ce_in        = 1'b1;
		iw_valid_in  = 1'b0;
		iw_data_in   = 16'h0;
		irq_in       = 1'b0;
		addr_mode_in = 2'h1;
		mem_ack_in   = 1'b0;
		mem_rdata_in = 32'h0;
		error_cnt    = 0;
		check_count  = 0;
		wr_cnt       = 0;
		for (int i = 0; i < 16; i++)
			regs[i] = $random(seed);
		repeat (2) @(negedge core_clk_in);
		rstn_in = 1'b1;
		@(negedge core_clk_in);
		srch(1, 1'b1, 1'b0, 1'b0, 16'h0001, 4'h6, 0);
		srch(2, 1'b0, 1'b1, 1'b0, 16'h0005, 4'h6, 3);
		srch(0, 1'b1, 1'b1, 1'b0, 16'h0000, 4'h8, 0);
		srch(1, 1'b0, 1'b1, 1'b1, 16'h0004, 4'h0, 0);
		// An unknown opcode pulses illegal for one cycle and leaves the unit idle
		send(16'hFFFF);
		iw_valid_in = 1'b0;
		chk("illegal", 32'({illegal_out, busy_out, iw_ready_out}), 32'h5);
		@(negedge core_clk_in);
		chk("illegal pulse", 32'(illegal_out), 32'h0);
		for (int i = 0; i < 64; i++) begin
			for (int j = 0; j < 16; j++)
				regs[j] = $random(seed);
			if (i % 4 != 3)
				plain(i % 4 + 3 * ((i / 4) % 2), ($random(seed) & 32'h7FFFFFFF) % 3);
			else
				srch(($random(seed) & 32'h7FFFFFFF) % 3, 1'($random(seed)), 1'($random(seed)),
				     ($random(seed) & 7) == 0, 16'(($random(seed) & 32'h7FFFFFFF) % 6 + 1), 4'(i / 4),
				     ($random(seed) & 7));
		end
		tally_and_finish();
	end
endmodule : cssu_core_bench
